// File: hdl/recloser_pkg.sv
// Shared types and constants for the breaker auto-reclose sequencer
package recloser_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int NUM_SHOTS     = 5;
  localparam int NUM_COUNTERS  = 8;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_RECLAIM  = 8'h04;
  localparam logic [7:0] ADDR_GRECLAIM = 8'h08;
  localparam logic [7:0] ADDR_EVT_EN   = 8'h0c;
  localparam logic [7:0] ADDR_SHOT0    = 8'h10;
  localparam logic [7:0] ADDR_SHOT4    = 8'h20;
  localparam logic [7:0] ADDR_MODE     = 8'h24;
  localparam logic [7:0] ADDR_STATUS   = 8'h28;
  localparam logic [7:0] ADDR_CNT_CLR  = 8'h2c;
  localparam logic [7:0] ADDR_CNT0     = 8'h30;
  localparam logic [7:0] ADDR_CNT7     = 8'h4c;
  localparam logic [7:0] ADDR_STAMP    = 8'h50;
  // Control register fields
  localparam int CTRL_USE_EN  = 0;
  localparam int CTRL_SHOTS_L = 1;
  localparam int CTRL_TWO_END = 4;
  localparam logic [2:0] SHOTS_RESET = 3'h1;
  // Counter indices
  localparam int CNT_SHOT    = 5;
  localparam int CNT_FINAL   = 6;
  localparam int CNT_SUCCESS = 7;

  typedef enum logic [3:0] {
    ST_READY    = 4'h0,
    ST_OPENING  = 4'h1,
    ST_DEAD     = 4'h3,
    ST_CLOSING  = 4'h2,
    ST_RECLAIM  = 4'h6,
    ST_GRECLAIM = 4'h7,
    ST_FINAL    = 4'h5,
    ST_LOCKED   = 4'h4,
    ST_HALTED   = 4'hc
  } seq_e;

  typedef struct packed {
    logic [4:0] req_on;
    logic [4:0] shot_run;
    logic       ready;
    logic       running;
    logic       dead_on;
    logic       arc_on;
    logic       reclaim_on;
    logic       seq_done;
    logic       final_trip;
    logic       locked;
    logic       halted;
    logic       enabled;
    logic       lock_after;
  } status_s;

  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] level;
    logic [31:0] stamp;
  } event_s;

  typedef struct packed {
    seq_e              st;
    logic [2:0]        shot;
    logic [2:0]        req;
    logic [15:0]       pre;
    logic              tick;
    logic [31:0]       ms;
    logic [15:0]       tmr;
    logic [15:0]       arc;
    logic              lock_after;
    logic              open_cmd;
    logic              close_cmd;
    logic              follower_open;
    logic              use_en;
    logic [2:0]        shots;
    logic              two_end;
    logic [15:0]       reclaim;
    logic [15:0]       greclaim;
    logic [15:0]       evt_en;
    logic [4:0][15:0]  dead;
    logic [4:0][15:0]  act;
    logic [9:0]        mode;
    logic [7:0][15:0]  cnt;
    logic [15:0]       evt_prev;
    logic              evt_v;
    event_s            evt;
    status_s           stat;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } core_s;
endpackage

// File: hdl/reclose_sequencer.sv
// Breaker auto-reclose sequencer with APB settings, counters and events
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module reclose_sequencer
  import recloser_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Reclose requests and control inputs
  input  wire logic        RECLOSE_REQUEST_FIRST,
  input  wire logic        RECLOSE_REQUEST_SECOND,
  input  wire logic        RECLOSE_REQUEST_THIRD,
  input  wire logic        RECLOSE_REQUEST_FOURTH,
  input  wire logic        RECLOSE_REQUEST_FIFTH,
  input  wire logic        RECLOSE_ENABLE_INPUT,
  input  wire logic        RECLOSE_MANUAL_RESET,
  input  wire logic        RECLOSE_LOCK_INPUT,
  input  wire logic        CRITICAL_LOCK_REQUEST,
  // Breaker object control and monitoring
  input  wire logic        BREAKER_CLOSED,
  input  wire logic        MANUAL_OPEN,
  input  wire logic        MANUAL_CLOSE,
  input  wire logic        OPERATION_FAILED,
  output logic             OBJECT_OPEN,
  output logic             OBJECT_CLOSE,
  output logic             FOLLOWER_OPEN,
  // Status and events
  output status_s          STATUS,
  output logic             EVENT_VALID,
  output event_s           EVENT
);

  core_s       s;
  core_s       next_s;
  logic [4:0]  reqv;
  logic        any_req;
  logic [2:0]  top;
  logic        en;
  logic        arc_sel;
  logic        disc_sel;
  logic        advance;
  logic        success;
  logic [7:0]  inc;
  logic [7:0]  clr;
  logic [15:0] cur;
  logic [15:0] changed;
  logic [3:0]  sidx;
  logic [31:0] rdat;
  logic        unmapped;
  logic        access;

  always_comb begin
    next_s = s;
    reqv = {RECLOSE_REQUEST_FIFTH, RECLOSE_REQUEST_FOURTH, RECLOSE_REQUEST_THIRD,
            RECLOSE_REQUEST_SECOND, RECLOSE_REQUEST_FIRST};
    any_req = |reqv;
    top = 3'h0;
    for (int i = NUM_SHOTS - 1; i >= 0; i--) begin
      if (reqv[i]) begin
        top = 3'(i);
      end
    end
    en = !s.use_en || RECLOSE_ENABLE_INPUT;
    // Live settings of the running shot are read every cycle
    arc_sel = s.mode[{s.shot, 1'b0}];
    disc_sel = s.mode[{s.shot, 1'b1}];
    advance = 1'b0;
    success = 1'b0;
    inc = 8'h00;
    clr = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick and timestamp
    next_s.tick = 1'b0;
    if (s.pre == 16'(TICK_COUNT - 1)) begin
      next_s.pre = 16'h0000;
      next_s.tick = 1'b1;
      next_s.ms = s.ms + 32'h00000001;
    end else begin
      next_s.pre = s.pre + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    case (s.st)
      ST_READY: begin
        next_s.open_cmd = 1'b0;
        next_s.close_cmd = 1'b0;
        next_s.follower_open = 1'b0;
        if (en && any_req && BREAKER_CLOSED) begin
          next_s.st = ST_OPENING;
          next_s.shot = 3'h0;
          next_s.req = top;
          next_s.open_cmd = 1'b1;
          next_s.follower_open = s.two_end;
          inc[top] = 1'b1;
          inc[CNT_SHOT] = 1'b1;
        end
      end
      ST_OPENING: begin
        if (OPERATION_FAILED) begin
          next_s.st = ST_LOCKED;
          next_s.open_cmd = 1'b0;
        end else if (!BREAKER_CLOSED) begin
          next_s.st = ST_DEAD;
          next_s.open_cmd = 1'b0;
          next_s.tmr = 16'h0000;
        end
      end
      ST_DEAD: begin
        if (s.tick) begin
          next_s.tmr = s.tmr + 16'h0001;
        end
        if (s.tmr >= s.dead[s.shot]) begin
          next_s.st = ST_CLOSING;
          next_s.close_cmd = 1'b1;
        end
      end
      ST_CLOSING: begin
        if (OPERATION_FAILED) begin
          next_s.st = ST_LOCKED;
          next_s.close_cmd = 1'b0;
        end else if (BREAKER_CLOSED) begin
          next_s.st = ST_RECLAIM;
          next_s.close_cmd = 1'b0;
          next_s.tmr = 16'h0000;
          next_s.arc = 16'h0000;
        end
      end
      ST_RECLAIM: begin
        if (s.tick) begin
          next_s.tmr = s.tmr + 16'h0001;
        end
        if (arc_sel) begin
          if (any_req && s.tick) begin
            next_s.arc = s.arc + 16'h0001;
          end
          if (any_req && s.arc >= s.act[s.shot]) begin
            advance = 1'b1;
          end else if (s.tmr >= s.reclaim) begin
            success = 1'b1;
          end
        end else if (disc_sel && any_req && s.tmr < s.act[s.shot]) begin
          next_s.st = ST_HALTED;
        end else if (any_req) begin
          advance = 1'b1;
        end else if (s.tmr >= s.reclaim) begin
          success = 1'b1;
        end
      end
      ST_GRECLAIM: begin
        if (s.tick) begin
          next_s.tmr = s.tmr + 16'h0001;
        end
        if (any_req) begin
          next_s.st = ST_FINAL;
          next_s.open_cmd = 1'b1;
          inc[CNT_FINAL] = 1'b1;
        end else if (s.tmr >= s.greclaim) begin
          next_s.st = s.lock_after ? ST_LOCKED : ST_READY;
        end
      end
      ST_FINAL: begin
        if (!BREAKER_CLOSED || OPERATION_FAILED) begin
          next_s.st = ST_LOCKED;
          next_s.open_cmd = 1'b0;
        end
      end
      ST_LOCKED: begin
        next_s.open_cmd = 1'b0;
        next_s.close_cmd = 1'b0;
        if (RECLOSE_MANUAL_RESET && !RECLOSE_LOCK_INPUT) begin
          next_s.st = ST_READY;
          next_s.lock_after = 1'b0;
        end
      end
      ST_HALTED: begin
        // No open or close command while halted; FOLLOWER_OPEN keeps its value
        next_s.open_cmd = 1'b0;
        next_s.close_cmd = 1'b0;
        if (RECLOSE_MANUAL_RESET && BREAKER_CLOSED) begin
          next_s.st = ST_READY;
        end
      end
      default: begin
        next_s.st = ST_LOCKED;
      end
    endcase

    if (advance) begin
      inc[top] = 1'b1;
      // Shot count above five is clamped so the shot index never leaves the table
      if (s.shot + 3'h1 < s.shots && s.shot < 3'(NUM_SHOTS - 1)) begin
        next_s.shot = s.shot + 3'h1;
        next_s.st = ST_OPENING;
        next_s.open_cmd = 1'b1;
        inc[CNT_SHOT] = 1'b1;
      end else begin
        next_s.st = ST_FINAL;
        next_s.open_cmd = 1'b1;
        inc[CNT_FINAL] = 1'b1;
      end
    end
    if (success) begin
      next_s.follower_open = 1'b0;
      next_s.tmr = 16'h0000;
      next_s.st = ST_GRECLAIM;
      inc[CNT_SUCCESS] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Manual breaker operation, locking and critical request
    if (s.st != ST_READY && s.st != ST_LOCKED && s.st != ST_HALTED) begin
      if (MANUAL_CLOSE && s.st == ST_DEAD) begin
        next_s.st = ST_GRECLAIM;
        next_s.lock_after = 1'b1;
        next_s.tmr = 16'h0000;
        next_s.open_cmd = 1'b0;
        next_s.close_cmd = 1'b0;
      end else if (MANUAL_OPEN || MANUAL_CLOSE) begin
        next_s.st = ST_READY;
        next_s.open_cmd = 1'b0;
        next_s.close_cmd = 1'b0;
      end
    end
    if (!en && s.st == ST_READY) begin
      next_s.st = ST_READY;
    end
    if (RECLOSE_LOCK_INPUT || CRITICAL_LOCK_REQUEST) begin
      next_s.st = ST_LOCKED;
      next_s.open_cmd = 1'b0;
      next_s.close_cmd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, write lands on the edge that sees PREADY
    access = PSEL && PENABLE;
    sidx = 4'(PADDR[7:2] - ADDR_SHOT0[7:2]);
    unmapped = 1'b0;
    rdat = 32'h00000000;
    case (PADDR)
      ADDR_CTRL:     rdat = {27'h0, s.two_end, s.shots, s.use_en};
      ADDR_RECLAIM:  rdat = {16'h0, s.reclaim};
      ADDR_GRECLAIM: rdat = {16'h0, s.greclaim};
      ADDR_EVT_EN:   rdat = {16'h0, s.evt_en};
      ADDR_MODE:     rdat = {22'h0, s.mode};
      ADDR_STATUS:   rdat = {11'h0, s.stat};
      ADDR_CNT_CLR:  rdat = 32'h00000000;
      ADDR_STAMP:    rdat = s.ms;
      default: begin
        if (PADDR >= ADDR_SHOT0 && PADDR <= ADDR_SHOT4 && PADDR[1:0] == 2'h0) begin
          rdat = {s.act[sidx[2:0]], s.dead[sidx[2:0]]};
        end else if (PADDR >= ADDR_CNT0 && PADDR <= ADDR_CNT7 && PADDR[1:0] == 2'h0) begin
          rdat = {16'h0, s.cnt[3'(PADDR[7:2] - ADDR_CNT0[7:2])]};
        end else begin
          unmapped = 1'b1;
        end
      end
    endcase
    if (access && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = PWRITE ? 32'h00000000 : rdat;
      next_s.pslverr = unmapped;
      for (int i = 0; i < NUM_SHOTS; i++) begin
        if (PWRITE && PADDR == ADDR_MODE && PWDATA[2 * i] && PWDATA[2 * i + 1]) begin
          next_s.pslverr = 1'b1;
        end
      end
    end else begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end
    if (access && s.pready && PWRITE && !s.pslverr) begin
      case (PADDR)
        ADDR_CTRL: begin
          next_s.use_en = PWDATA[CTRL_USE_EN];
          next_s.shots = PWDATA[CTRL_SHOTS_L +: 3];
          next_s.two_end = PWDATA[CTRL_TWO_END];
        end
        ADDR_RECLAIM:  next_s.reclaim = PWDATA[15:0];
        ADDR_GRECLAIM: next_s.greclaim = PWDATA[15:0];
        ADDR_EVT_EN:   next_s.evt_en = PWDATA[15:0];
        ADDR_MODE:     next_s.mode = PWDATA[9:0];
        ADDR_CNT_CLR:  clr = PWDATA[7:0];
        default: begin
          if (PADDR >= ADDR_SHOT0 && PADDR <= ADDR_SHOT4) begin
            next_s.dead[sidx[2:0]] = PWDATA[15:0];
            next_s.act[sidx[2:0]] = PWDATA[31:16];
          end
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counters: a count in the same cycle as a clear is added after the clear, giving one
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (inc[i]) begin
        next_s.cnt[i] = (clr[i] ? 16'h0000 : s.cnt[i]) + 16'h0001;
      end else if (clr[i]) begin
        next_s.cnt[i] = 16'h0000;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status and time-stamped change events
    next_s.stat.req_on = (s.st == ST_READY || s.st == ST_LOCKED || s.st == ST_HALTED)
                         ? 5'h00 : 5'(5'h01 << s.req);
    next_s.stat.shot_run = (s.st == ST_READY || s.st == ST_LOCKED || s.st == ST_HALTED
                            || s.st == ST_GRECLAIM) ? 5'h00 : 5'(5'h01 << s.shot);
    next_s.stat.ready = s.st == ST_READY && en;
    next_s.stat.running = s.st inside {ST_OPENING, ST_DEAD, ST_CLOSING, ST_RECLAIM};
    next_s.stat.dead_on = s.st == ST_DEAD;
    next_s.stat.arc_on = s.st == ST_RECLAIM && arc_sel && any_req;
    next_s.stat.reclaim_on = s.st == ST_RECLAIM || s.st == ST_GRECLAIM;
    next_s.stat.seq_done = s.st == ST_RECLAIM && s.shot + 3'h1 >= s.shots;
    next_s.stat.final_trip = s.st == ST_FINAL;
    next_s.stat.locked = s.st == ST_LOCKED;
    next_s.stat.halted = s.st == ST_HALTED;
    next_s.stat.enabled = en;
    next_s.stat.lock_after = s.lock_after;
    cur = {reqv, RECLOSE_ENABLE_INPUT, RECLOSE_MANUAL_RESET, RECLOSE_LOCK_INPUT,
           CRITICAL_LOCK_REQUEST, s.open_cmd, s.close_cmd, s.stat.ready,
           s.stat.running, s.stat.final_trip, s.stat.locked, s.stat.halted};
    changed = (cur ^ s.evt_prev) & s.evt_en;
    next_s.evt_prev = cur;
    next_s.evt_v = |changed;
    next_s.evt.mask = changed;
    next_s.evt.level = cur;
    next_s.evt.stamp = s.ms;
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      s <= '0;
      s.st <= ST_READY;
      s.shots <= SHOTS_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign OBJECT_OPEN = s.open_cmd;
  assign OBJECT_CLOSE = s.close_cmd;
  assign FOLLOWER_OPEN = s.follower_open;
  assign STATUS = s.stat;
  assign EVENT_VALID = s.evt_v;
  assign EVENT = s.evt;

endmodule

// File: dv/reclose_sequencer_asserts.sv
// Port-level concurrent checks for the reclose sequencer
`timescale 1ns/10ps
module reclose_sequencer_asserts
  import recloser_pkg::*;
(
  // Clock, reset and bus handshake
  input wire logic    REF_CLK,
  input wire logic    RESET,
  input wire logic    PSEL,
  input wire logic    PENABLE,
  input wire logic    PREADY,
  input wire logic    PSLVERR,
  // Requests and controls
  input wire logic    RECLOSE_REQUEST_FIRST,
  input wire logic    RECLOSE_REQUEST_SECOND,
  input wire logic    RECLOSE_REQUEST_THIRD,
  input wire logic    RECLOSE_REQUEST_FOURTH,
  input wire logic    RECLOSE_REQUEST_FIFTH,
  input wire logic    RECLOSE_LOCK_INPUT,
  input wire logic    CRITICAL_LOCK_REQUEST,
  // Breaker side and status
  input wire logic    BREAKER_CLOSED,
  input wire logic    OBJECT_OPEN,
  input wire logic    OBJECT_CLOSE,
  input wire status_s STATUS
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  wire logic req_any = RECLOSE_REQUEST_FIRST | RECLOSE_REQUEST_SECOND | RECLOSE_REQUEST_THIRD |
                       RECLOSE_REQUEST_FOURTH | RECLOSE_REQUEST_FIFTH;
  sequence s_access;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_answer;
    PREADY ##1 !PREADY;
  endsequence
  property p_apb_answer;
    s_access |=> s_answer;
  endproperty
  property p_err_with_ready;
    PSLVERR |-> PREADY;
  endproperty
  property p_cmd_exclusive;
    !(OBJECT_OPEN && OBJECT_CLOSE);
  endproperty
  property p_open_cause;
    $rose(OBJECT_OPEN) |-> $past(req_any);
  endproperty
  property p_open_drop;
    OBJECT_OPEN && !BREAKER_CLOSED |=> !OBJECT_OPEN;
  endproperty
  property p_close_drop;
    OBJECT_CLOSE && BREAKER_CLOSED |=> !OBJECT_CLOSE;
  endproperty
  property p_crit_lock;
    $rose(CRITICAL_LOCK_REQUEST) |-> ##[1:3] STATUS.locked;
  endproperty
  property p_lock_hold;
    RECLOSE_LOCK_INPUT [*3] |-> !STATUS.ready;
  endproperty
  property p_halt_quiet;
    STATUS.halted |-> !OBJECT_OPEN && !OBJECT_CLOSE;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("bus answer not one cycle after access");
  a_err_with_ready: assert property (p_err_with_ready) else $error("error flag without ready");
  a_cmd_exclusive: assert property (p_cmd_exclusive) else $error("open and close together");
  a_open_cause: assert property (p_open_cause) else $error("open without request");
  a_open_drop: assert property (p_open_drop) else $error("open held after breaker open");
  a_close_drop: assert property (p_close_drop) else $error("close held after breaker closed");
  a_crit_lock: assert property (p_crit_lock) else $error("critical request did not lock");
  a_lock_hold: assert property (p_lock_hold) else $error("ready while lock input high");
  a_halt_quiet: assert property (p_halt_quiet) else $error("command while halted");
endmodule

bind reclose_sequencer reclose_sequencer_asserts i_chk (
  .REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .RECLOSE_REQUEST_FIRST(RECLOSE_REQUEST_FIRST), .RECLOSE_REQUEST_SECOND(RECLOSE_REQUEST_SECOND),
  .RECLOSE_REQUEST_THIRD(RECLOSE_REQUEST_THIRD), .RECLOSE_REQUEST_FOURTH(RECLOSE_REQUEST_FOURTH),
  .RECLOSE_REQUEST_FIFTH(RECLOSE_REQUEST_FIFTH), .RECLOSE_LOCK_INPUT(RECLOSE_LOCK_INPUT),
  .CRITICAL_LOCK_REQUEST(CRITICAL_LOCK_REQUEST), .BREAKER_CLOSED(BREAKER_CLOSED),
  .OBJECT_OPEN(OBJECT_OPEN), .OBJECT_CLOSE(OBJECT_CLOSE), .STATUS(STATUS));

// File: dv/breaker_model.sv
// Behavioural breaker with object control supervision
`timescale 1ns/10ps
module breaker_model (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Commands and test controls
  input wire logic       open_cmd,
  input wire logic       close_cmd,
  input wire logic       fail_next,
  input wire logic [7:0] lag,
  // Position and supervision report
  output logic           closed,
  output logic           failed
);
  logic [7:0] cnt;
  // Operation completes after lag+1 cycles, or reports a failure instead
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      closed <= 1'b1;
      failed <= 1'b0;
      cnt    <= 8'h00;
    end else begin
      failed <= 1'b0;
      if ((open_cmd && closed) || (close_cmd && !closed)) begin
        cnt <= cnt + 8'h01;
        if (cnt >= lag) begin
          cnt <= 8'h00;
          if (fail_next)
            failed <= 1'b1;
          else
            closed <= close_cmd;
        end
      end else
        cnt <= 8'h00;
    end
  end
endmodule

// File: dv/test_breaker_auto_reclose_sequencer.sv
// Self-checking bench for the reclose sequencer
`timescale 1ns/10ps
module test_breaker_auto_reclose_sequencer;
  import recloser_pkg::*;
  logic        REF_CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [4:0]  req = 5'h00;
  logic        en_in = 1'b1;
  logic        mrst = 1'b0;
  logic        lock_in = 1'b0;
  logic        crit = 1'b0;
  logic        fail_next = 1'b0;
  logic [7:0]  lag = 8'h02;
  logic        evt_crit = 1'b0;
  logic        man_open = 1'b0;
  logic        man_close = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, BREAKER_CLOSED, OPERATION_FAILED, OBJECT_OPEN, OBJECT_CLOSE;
  logic        FOLLOWER_OPEN, EVENT_VALID;
  status_s     STATUS;
  event_s      EVENT;
  int          error_cnt = 0;
  int          n_tests = 0;
  logic [31:0] r;
  logic        e;
  wire logic [5:0] watch = {BREAKER_CLOSED, STATUS.halted, STATUS.locked, STATUS.ready, OBJECT_CLOSE, OBJECT_OPEN};

  always #10 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK)
    if (EVENT_VALID === 1'b1 && EVENT.mask[7] === 1'b1 && EVENT.level[7] === 1'b1) evt_crit <= 1'b1;

  reclose_sequencer #(.TICK_COUNT(10)) i_dut (
    .REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RECLOSE_REQUEST_FIRST(req[0]), .RECLOSE_REQUEST_SECOND(req[1]), .RECLOSE_REQUEST_THIRD(req[2]),
    .RECLOSE_REQUEST_FOURTH(req[3]), .RECLOSE_REQUEST_FIFTH(req[4]), .RECLOSE_ENABLE_INPUT(en_in),
    .RECLOSE_MANUAL_RESET(mrst), .RECLOSE_LOCK_INPUT(lock_in), .CRITICAL_LOCK_REQUEST(crit),
    .BREAKER_CLOSED(BREAKER_CLOSED), .MANUAL_OPEN(man_open), .MANUAL_CLOSE(man_close),
    .OPERATION_FAILED(OPERATION_FAILED), .OBJECT_OPEN(OBJECT_OPEN), .OBJECT_CLOSE(OBJECT_CLOSE),
    .FOLLOWER_OPEN(FOLLOWER_OPEN), .STATUS(STATUS), .EVENT_VALID(EVENT_VALID), .EVENT(EVENT));

  breaker_model i_brk (
    .clk(REF_CLK), .rst(RESET), .open_cmd(OBJECT_OPEN), .close_cmd(OBJECT_CLOSE),
    .fail_next(fail_next), .lag(lag), .closed(BREAKER_CLOSED), .failed(OPERATION_FAILED));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask

  // Waits at least one edge for a watched signal to reach a level
  task automatic wait_on(input int i, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (watch[i] !== v && n < 4000);
    chk($sformatf("wait %0d", i), {31'h0, watch[i]}, {31'h0, v});
    if (watch[i] !== v) close_out;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
    if (n >= 50) begin
      chk("pready", 32'h0, 32'h1);
      close_out;
    end
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, r, exp);
  endtask

  task automatic lock_case(input int i);
    if (i == 0) lock_in <= 1'b1;
    else crit <= 1'b1;
    wait_on(3, 1'b1);
    lock_in <= 1'b0;
    crit <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    chk("ready locked", {31'h0, STATUS.ready}, 32'h0);
    mrst <= 1'b1;
    wait_on(2, 1'b1);
    mrst <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    rd("ctrl reset", ADDR_CTRL, {28'h0, SHOTS_RESET, 1'b0});
    apb(1'b1, 8'hfc, 32'h1);
    chk("unmapped err", {31'h0, e}, 32'h1);
    apb(1'b1, ADDR_MODE, 32'h3);
    chk("mode both err", {31'h0, e}, 32'h1);
    rd("mode kept", ADDR_MODE, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h4);
    apb(1'b1, ADDR_SHOT0, 32'h2);
    apb(1'b1, ADDR_SHOT0 + 8'h04, 32'h2);
    apb(1'b1, ADDR_RECLAIM, 32'h32);
    apb(1'b1, ADDR_EVT_EN, 32'hffff);
    $display("test registers done");
    req <= 5'h0a;
    wait_on(0, 1'b1);
    repeat (2) @(posedge REF_CLK);
    chk("req_on", {27'h0, STATUS.req_on}, 32'h2);
    wait_on(5, 1'b0);
    req <= 5'h00;
    wait_on(5, 1'b1);
    req <= 5'h01;
    wait_on(0, 1'b1);
    repeat (2) @(posedge REF_CLK);
    chk("shot_run", {27'h0, STATUS.shot_run}, 32'h2);
    wait_on(5, 1'b0);
    req <= 5'h00;
    wait_on(2, 1'b1);
    rd("cnt reclose_request_first", ADDR_CNT0, 32'h1);
    rd("cnt reclose_request_second", ADDR_CNT0 + 8'h04, 32'h1);
    rd("cnt shots", ADDR_CNT0 + 8'h14, 32'h2);
    rd("cnt success", ADDR_CNT7, 32'h1);
    apb(1'b1, ADDR_CNT_CLR, 32'hff);
    rd("cnt cleared", ADDR_CNT7, 32'h0);
    $display("test shots done");
    for (int i = 0; i < 2; i++) lock_case(i);
    chk("crit event", {31'h0, evt_crit}, 32'h1);
    $display("test locks done");
    apb(1'b1, ADDR_MODE, 32'h2);
    apb(1'b1, ADDR_SHOT0, 32'h00640002);
    lag <= 8'h1e;
    req <= 5'h01;
    wait_on(5, 1'b0);
    req <= 5'h00;
    wait_on(5, 1'b1);
    req <= 5'h04;
    wait_on(4, 1'b1);
    repeat (20) @(posedge REF_CLK);
    chk("halt cmd", {31'h0, OBJECT_OPEN | OBJECT_CLOSE}, 32'h0);
    req <= 5'h00;
    mrst <= 1'b1;
    wait_on(2, 1'b1);
    mrst <= 1'b0;
    lag <= 8'h02;
    apb(1'b1, ADDR_MODE, 32'h0);
    $display("test discrimination done");
    fail_next <= 1'b1;
    req <= 5'h10;
    wait_on(3, 1'b1);
    req <= 5'h00;
    fail_next <= 1'b0;
    mrst <= 1'b1;
    wait_on(2, 1'b1);
    mrst <= 1'b0;
    $display("test failure done");
    apb(1'b1, ADDR_CTRL, 32'h5);
    en_in <= 1'b0;
    req <= 5'h01;
    repeat (6) @(posedge REF_CLK);
    chk("disabled", {30'h0, STATUS.enabled, OBJECT_OPEN}, 32'h0);
    req <= 5'h00;
    en_in <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    chk("enabled", {31'h0, STATUS.enabled}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h14);
    req <= 5'h01;
    wait_on(5, 1'b0);
    req <= 5'h00;
    chk("follower open", {31'h0, FOLLOWER_OPEN}, 32'h1);
    wait_on(2, 1'b1);
    repeat (2) @(posedge REF_CLK);
    chk("follower free", {31'h0, FOLLOWER_OPEN}, 32'h0);
    $display("test enable and two-end done");
    // Arcing on shot 0 with 4 ms budget, spent over two separate activations
    apb(1'b1, ADDR_MODE, 32'h1);
    apb(1'b1, ADDR_SHOT0, 32'h00040002);
    req <= 5'h01;
    wait_on(5, 1'b0);
    req <= 5'h00;
    wait_on(5, 1'b1);
    req <= 5'h01;
    repeat (25) @(posedge REF_CLK);
    req <= 5'h00;
    repeat (20) @(posedge REF_CLK);
    req <= 5'h01;
    repeat (26) @(posedge REF_CLK);
    chk("arc sum", {27'h0, STATUS.shot_run}, 32'h2);
    req <= 5'h00;
    wait_on(2, 1'b1);
    // Manual open during reclaim returns to ready at once
    req <= 5'h01;
    wait_on(5, 1'b0);
    req <= 5'h00;
    wait_on(5, 1'b1);
    man_open <= 1'b1;
    @(posedge REF_CLK);
    man_open <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    chk("manual open", {31'h0, STATUS.ready}, 32'h1);
    // Manual close during dead time gives general reclaim, then lock-out
    req <= 5'h01;
    wait_on(5, 1'b0);
    man_close <= 1'b1;
    req <= 5'h00;
    @(posedge REF_CLK);
    man_close <= 1'b0;
    wait_on(3, 1'b1);
    chk("lock after", {31'h0, STATUS.lock_after}, 32'h1);
    $display("test arcing and manual operation done");
    close_out;
  end
endmodule
